/* core/cpw_top.sv */
// module: counter array pwm channels with channel-5 watchdog
`timescale 1ns/1ps
module cpw_top (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        cpu_idle,
    input  wire logic        timer_overflow,
    input  wire logic        ext_count_pin,
    output logic [5:0]       channel_output_pin,
    output logic             watchdog_reset
);
    cpw_pkg::cpw_top_t q_reg;
    cpw_pkg::cpw_top_t q_next;
    cpw_pkg::cpw_evt_t evt;

    logic        tick;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    logic        wdt_en;
    logic [15:0] cnt_nxt;
    logic [15:0] msk_n;
    logic [7:0]  wd;
    logic [3:0]  slot;
    logic [3:0]  sub;
    logic [5:0]  wr_mode;
    logic [5:0]  wr_lo;
    logic [5:0]  wr_hi;
    logic [5:0]  match;

    cpw_prescale u_prescale (
        .clk            (clk),
        .reset_n        (reset_n),
        .sel            (q_reg.cps),
        .timer_overflow (timer_overflow),
        .ext_count_pin  (ext_count_pin),
        .tick           (tick)
    );

    cpw_wb_slave u_wb (
        .clk      (clk),
        .reset_n  (reset_n),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_sel_i (wb_sel_i),
        .rdata    (rdata),
        .wb_ack_o (wb_ack_o),
        .wb_dat_o (wb_dat_o),
        .wr_stb   (wr_stb),
        .rd_stb   (rd_stb)
    );

    assign wd      = wb_dat_i[7:0];
    assign slot    = wb_adr_i[7:4];
    assign sub     = wb_adr_i[3:0];
    assign wdt_en  = q_reg.watchdog_enable | q_reg.watchdog_lock;
    assign cnt_nxt = q_reg.cnt + 16'h0001;
    assign msk_n   = cpw_pkg::cycle_mask(q_reg.cycle_length_field);

    // counter steps and overflow events
    always_comb begin
        evt.step  = tick & (q_reg.cr | wdt_en) & ~(q_reg.idle_suspend & cpu_idle);
        evt.ovf8  = evt.step & (q_reg.cnt[7:0] == 8'hFF);
        evt.ovf16 = evt.step & (q_reg.cnt == 16'hFFFF);
        evt.ovfn  = evt.step & ((q_reg.cnt | ~msk_n) == 16'hFFFF);
    end

    // per-channel write strobes
    generate
        for (genvar i = 0; i < cpw_pkg::NUM_CH; i++) begin : g_dec
            localparam logic [3:0] SLOT = cpw_pkg::CH_SLOT_FIRST + 4'(i);
            assign wr_mode[i] = wr_stb & (slot == SLOT)
                              & (sub == cpw_pkg::CH_OFS_MODE);
            assign wr_lo[i]   = wr_stb & (slot == SLOT)
                              & (sub == cpw_pkg::CH_OFS_LO);
            assign wr_hi[i]   = wr_stb & (slot == SLOT)
                              & (sub == cpw_pkg::CH_OFS_HI);
        end
    endgenerate

    // channels, counter, control registers and watchdog
    always_comb begin
        logic        is_wdt;
        logic [7:0]  md;
        logic        pwm;
        logic        wide;
        logic        ovf;
        logic        hit;
        logic [15:0] msk;
        logic [15:0] cmp_a;
        is_wdt = 1'b0;
        md     = 8'h00;
        pwm    = 1'b0;
        wide   = 1'b0;
        ovf    = 1'b0;
        hit    = 1'b0;
        msk    = 16'h0000;
        cmp_a  = 16'h0000;
        q_next = q_reg;
        match  = 6'h00;
        q_next.wdt_rst = 1'b0;

        for (int i = 0; i < cpw_pkg::NUM_CH; i++) begin
            is_wdt = wdt_en && (i == cpw_pkg::WDT_CHANNEL);
            // with the watchdog on, channel 5 runs as a plain timer
            md    = is_wdt ? cpw_pkg::WDT_MODE : q_reg.ch[i].mode;
            pwm   = md[cpw_pkg::CM_PWM];
            // wide mode ignores the shared length
            wide  = pwm & md[cpw_pkg::CM_PWM16];
            cmp_a = q_reg.ch[i].cmp;
            if (wide) begin
                ovf = evt.ovf16;
                msk = 16'hFFFF;
            end else if (q_reg.cycle_length_field == 2'h0) begin
                ovf = evt.ovfn;
                msk = msk_n;
                if (ovf) begin
                    cmp_a[7:0] = q_reg.ch[i].cmp[15:8];
                end
            end else begin
                ovf = evt.ovfn;
                msk = msk_n;
                if (ovf) begin
                    cmp_a = q_reg.ch[i].rld;
                end
            end
            if (evt.step) begin
                if (pwm) begin
                    q_next.ch[i].cmp = cmp_a;
                    hit = ((cnt_nxt ^ cmp_a) & msk) == 16'h0000;
                    if (hit && md[cpw_pkg::CM_ECOM]) begin
                        q_next.ch[i].pin = 1'b1;
                        match[i] = md[cpw_pkg::CM_MAT];
                    end else if (ovf) begin
                        q_next.ch[i].pin = 1'b0;
                    end
                end else begin
                    hit = cnt_nxt == q_reg.ch[i].cmp;
                    match[i] = hit & md[cpw_pkg::CM_ECOM]
                             & md[cpw_pkg::CM_MAT];
                end
            end
            // compare enable off means output low
            if (!md[cpw_pkg::CM_ECOM] || is_wdt) begin
                q_next.ch[i].pin = 1'b0;
            end
            if (wr_mode[i] && !is_wdt) begin
                q_next.ch[i].mode = wd;
            end
            if (wr_lo[i]) begin
                if (q_reg.reload_select) begin
                    q_next.ch[i].rld[7:0] = wd;
                end else begin
                    q_next.ch[i].cmp[7:0] = wd;
                end
                q_next.ch[i].mode[cpw_pkg::CM_ECOM] = 1'b0;
            end
            if (wr_hi[i]) begin
                if (is_wdt) begin
                    // timeout set by offset and low byte
                    q_next.ch[i].cmp[15:8] = q_reg.cnt[15:8]
                                           + q_reg.ch[i].cmp[7:0];
                end else if (q_reg.reload_select) begin
                    q_next.ch[i].rld[15:8] = wd;
                end else begin
                    q_next.ch[i].cmp[15:8] = wd;
                end
                q_next.ch[i].mode[cpw_pkg::CM_ECOM] = 1'b1;
            end
        end

        // counter advance; watchdog blocks byte writes
        if (evt.step) begin
            q_next.cnt = cnt_nxt;
        end
        if (wr_stb && !wdt_en && wb_adr_i == cpw_pkg::OFS_CNT_LO) begin
            q_next.cnt[7:0] = wd;
        end
        if (wr_stb && !wdt_en && wb_adr_i == cpw_pkg::OFS_CNT_HI) begin
            q_next.cnt[15:8] = wd;
        end

        // control and configuration writes
        if (wr_stb && wb_adr_i == cpw_pkg::OFS_CTRL) begin
            q_next.cf  = wd[cpw_pkg::CTRL_CF];
            // run bit stored; the watchdog keeps the counter going
            q_next.cr  = wd[cpw_pkg::CTRL_CR];
            q_next.ccf = wd[5:0];
            if (wdt_en && wd[cpw_pkg::WDT_CHANNEL]) begin
                q_next.wdt_rst = 1'b1;
            end
        end
        if (wr_stb && wb_adr_i == cpw_pkg::OFS_MODE) begin
            if (!wdt_en) begin
                q_next.idle_suspend = wd[cpw_pkg::MODE_IDLE_SUSPEND];
                q_next.cps  = wd[cpw_pkg::MODE_CPS +: 3];
            end
            // lock sets only; it keeps the watchdog on
            q_next.watchdog_enable  = wd[cpw_pkg::MODE_WATCHDOG_ENABLE];
            q_next.watchdog_lock = q_reg.watchdog_lock | wd[cpw_pkg::MODE_WATCHDOG_LOCK];
            q_next.ecf   = wd[cpw_pkg::MODE_ECF];
        end
        if (wr_stb && wb_adr_i == cpw_pkg::OFS_PWMCFG) begin
            q_next.reload_select = wd[cpw_pkg::CFG_RELOAD_SELECT];
            q_next.ecov  = wd[cpw_pkg::CFG_ECOV];
            q_next.pwm_overflow_flag  = wd[cpw_pkg::CFG_PWM_OVERFLOW_FLAG];
            q_next.cycle_length_field = wd[1:0];
        end

        // hardware sets win over software clears
        if (evt.ovf16) begin
            q_next.cf = 1'b1;
        end
        // overflow flag at each cycle wrap
        if (evt.ovfn) begin
            q_next.pwm_overflow_flag = 1'b1;
        end
        q_next.ccf = q_next.ccf | match;

        // channel 5 high byte against counter high
        // high byte match arms the reset
        // fires as the low byte wraps
        if (wdt_en && evt.ovf8
            && q_reg.ch[cpw_pkg::WDT_CHANNEL].cmp[15:8] == q_reg.cnt[15:8])
        begin
            q_next.wdt_rst = 1'b1;
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        logic [7:0] r;
        logic [3:0] ci;
        logic [7:0] md;
        r  = 8'h00;
        ci = slot - cpw_pkg::CH_SLOT_FIRST;
        md = 8'h00;
        if (!rd_stb) begin
            r = 8'h00;
        end else if (wb_adr_i == cpw_pkg::OFS_CTRL) begin
            // run bit reads the user setting
            r = {q_reg.cf, q_reg.cr, q_reg.ccf};
        end else if (wb_adr_i == cpw_pkg::OFS_MODE) begin
            r = {q_reg.idle_suspend, q_reg.watchdog_enable, q_reg.watchdog_lock, 1'b0,
                 q_reg.cps, q_reg.ecf};
        end else if (wb_adr_i == cpw_pkg::OFS_PWMCFG) begin
            r = {q_reg.reload_select, q_reg.ecov, q_reg.pwm_overflow_flag, 3'h0, q_reg.cycle_length_field};
        end else if (wb_adr_i == cpw_pkg::OFS_CNT_LO) begin
            r = q_reg.cnt[7:0];
        end else if (wb_adr_i == cpw_pkg::OFS_CNT_HI) begin
            r = q_reg.cnt[15:8];
        end else if (slot >= cpw_pkg::CH_SLOT_FIRST
                     && ci < 4'(cpw_pkg::NUM_CH)) begin
            md = (wdt_en && ci == 4'(cpw_pkg::WDT_CHANNEL))
               ? cpw_pkg::WDT_MODE : q_reg.ch[ci[2:0]].mode;
            if (sub == cpw_pkg::CH_OFS_MODE) begin
                r = md;
            end else if (sub == cpw_pkg::CH_OFS_LO) begin
                r = q_reg.reload_select ? q_reg.ch[ci[2:0]].rld[7:0]
                                : q_reg.ch[ci[2:0]].cmp[7:0];
            end else if (sub == cpw_pkg::CH_OFS_HI) begin
                r = q_reg.reload_select ? q_reg.ch[ci[2:0]].rld[15:8]
                                : q_reg.ch[ci[2:0]].cmp[15:8];
            end
        end
        rdata = {24'h00_0000, r};
    end

    // state register; watchdog comes up enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg       <= '0;
            q_reg.watchdog_enable  <= 1'b1;
            q_reg.cps   <= cpw_pkg::CPS_RST;
            q_reg.cycle_length_field <= cpw_pkg::CYCLE_LENGTH_FIELD_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // outputs straight from state flops
    generate
        for (genvar i = 0; i < cpw_pkg::NUM_CH; i++) begin : g_pin
            assign channel_output_pin[i] = q_reg.ch[i].pin;
        end
    endgenerate
    assign watchdog_reset = q_reg.wdt_rst;
endmodule

/* core/cpw_pkg.sv */
// package: constants, types and shared decoding for the counter array
package cpw_pkg;

    localparam int unsigned NUM_CH      = 6;
    localparam int unsigned WDT_CHANNEL = 5;

    // register byte offsets, one 32-bit word each
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_MODE    = 8'h04;
    localparam logic [7:0] OFS_PWMCFG  = 8'h08;
    localparam logic [7:0] OFS_CNT_LO  = 8'h0C;
    localparam logic [7:0] OFS_CNT_HI  = 8'h10;
    // channel n sits in slot (n + CH_SLOT_FIRST), address bits [7:4]
    localparam logic [3:0] CH_SLOT_FIRST = 4'h2;
    localparam logic [3:0] CH_OFS_MODE   = 4'h0;
    localparam logic [3:0] CH_OFS_LO     = 4'h4;
    localparam logic [3:0] CH_OFS_HI     = 4'h8;

    // array_control_register fields
    localparam int unsigned CTRL_CF  = 7;
    localparam int unsigned CTRL_CR  = 6;
    // array_mode_register fields
    localparam int unsigned MODE_IDLE_SUSPEND  = 7;
    localparam int unsigned MODE_WATCHDOG_ENABLE  = 6;
    localparam int unsigned MODE_WATCHDOG_LOCK = 5;
    localparam int unsigned MODE_CPS   = 1;
    localparam int unsigned MODE_ECF   = 0;
    // pwm_config_register fields
    localparam int unsigned CFG_RELOAD_SELECT = 7;
    localparam int unsigned CFG_ECOV  = 6;
    localparam int unsigned CFG_PWM_OVERFLOW_FLAG  = 5;
    // channel_mode_register fields
    localparam int unsigned CM_PWM16 = 7;
    localparam int unsigned CM_ECOM  = 6;
    localparam int unsigned CM_MAT   = 3;
    localparam int unsigned CM_PWM   = 1;

    // reset values and the fixed watchdog channel mode
    localparam logic [2:0] CPS_RST   = 3'h0;
    localparam logic [7:0] WDT_MODE  = 8'h40;
    localparam logic [1:0] CYCLE_LENGTH_FIELD_RST = 2'h0;

    // clock source codes and divider terminal counts
    localparam logic [2:0] CPS_DIV12 = 3'h0;
    localparam logic [2:0] CPS_DIV4  = 3'h1;
    localparam logic [2:0] CPS_TIMER = 3'h2;
    localparam logic [2:0] CPS_EXT   = 3'h3;
    localparam logic [2:0] CPS_SYS   = 3'h4;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV4_LAST  = 4'h3;

    // one counter step and its overflow events
    typedef struct packed {
        logic step;
        logic ovf8;
        logic ovfn;
        logic ovf16;
    } cpw_evt_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [15:0] cmp;
        logic [15:0] rld;
        logic        pin;
    } cpw_ch_t;

    typedef struct packed {
        logic [15:0]          cnt;
        logic                 cr;
        logic                 cf;
        logic [5:0]           ccf;
        logic                 idle_suspend;
        logic                 watchdog_enable;
        logic                 watchdog_lock;
        logic [2:0]           cps;
        logic                 ecf;
        logic                 reload_select;
        logic                 ecov;
        logic                 pwm_overflow_flag;
        logic [1:0]           cycle_length_field;
        logic                 wdt_rst;
        cpw_ch_t [5:0]        ch;
    } cpw_top_t;

    // bits of the counter that take part in an n-bit cycle
    function automatic logic [15:0] cycle_mask(input logic [1:0] cycle_length_field);
        case (cycle_length_field)
            2'h0:    cycle_mask = 16'h00FF;
            2'h1:    cycle_mask = 16'h01FF;
            2'h2:    cycle_mask = 16'h03FF;
            default: cycle_mask = 16'h07FF;
        endcase
    endfunction

endpackage

/* core/cpw_prescale.sv */
// module: counter clock source selection, one-cycle tick out
`timescale 1ns/1ps
module cpw_prescale (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] sel,
    input  wire logic       timer_overflow,
    input  wire logic       ext_count_pin,
    output logic            tick
);
    typedef struct packed {
        logic [3:0] div;
        logic       s1;
        logic       s2;
        logic       s3;
        logic       tick;
    } cpw_ps_t;

    cpw_ps_t q_reg;
    cpw_ps_t q_next;

    // divider and pin edge; s1 feeds only s2
    always_comb begin
        q_next      = q_reg;
        q_next.s1   = ext_count_pin;
        q_next.s2   = q_reg.s1;
        q_next.s3   = q_reg.s2;
        q_next.tick = 1'b0;
        q_next.div  = q_reg.div + 4'h1;
        case (sel)
            cpw_pkg::CPS_DIV4: begin
                if (q_reg.div >= cpw_pkg::DIV4_LAST) begin
                    q_next.div  = 4'h0;
                    q_next.tick = 1'b1;
                end
            end
            cpw_pkg::CPS_TIMER: q_next.tick = timer_overflow;
            cpw_pkg::CPS_EXT:   q_next.tick = q_reg.s2 & ~q_reg.s3;
            cpw_pkg::CPS_SYS:   q_next.tick = 1'b1;
            default: begin
                if (q_reg.div >= cpw_pkg::DIV12_LAST) begin
                    q_next.div  = 4'h0;
                    q_next.tick = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign tick = q_reg.tick;
endmodule

/* core/cpw_wb_slave.sv */
// module: classic wishbone slave handshake with registered read data
`timescale 1ns/1ps
module cpw_wb_slave (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] rdata,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    output logic             wr_stb,
    output logic             rd_stb
);
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } cpw_wb_t;

    cpw_wb_t q_reg;
    cpw_wb_t q_next;
    logic    access;

    // one answer per request; ack drops the cycle after it rose
    assign access = wb_cyc_i & wb_stb_i & ~q_reg.ack;
    assign wr_stb = access & wb_we_i & wb_sel_i[0];
    assign rd_stb = access & ~wb_we_i;

    always_comb begin
        q_next     = q_reg;
        q_next.ack = access;
        q_next.dat = rd_stb ? rdata : 32'h0000_0000;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign wb_ack_o = q_reg.ack;
    assign wb_dat_o = q_reg.dat;
endmodule

/* bench/cpw_top_asserts.sv */
// checker: bus handshake and watchdog pulse properties
`timescale 1ns/1ps
module cpw_top_asserts (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        watchdog_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic req;
    logic wr;
    logic on_reg;
    logic lck_reg;
    // a request is taken only while ack is low
    assign req = wb_cyc_i & wb_stb_i & !wb_ack_o;
    assign wr  = req & wb_we_i & wb_sel_i[0];
    // shadow of watchdog enable; lock keeps it on until reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            on_reg  <= 1'b1;
            lck_reg <= 1'b0;
        end else if (wr && wb_adr_i == 8'h04) begin
            on_reg  <= (|wb_dat_i[6:5]) | lck_reg;
            lck_reg <= wb_dat_i[5] | lck_reg;
        end
    end
    property p_ack_next; req |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_why;
        $rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i);
    endproperty
    a_ack_why: assert property (p_ack_why) else $error("ack unasked");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
    property p_dat_top; wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000; endproperty
    a_dat_top: assert property (p_dat_top) else $error("upper data set");
    property p_wdr_one; watchdog_reset |=> !watchdog_reset; endproperty
    a_wdr_one: assert property (p_wdr_one) else $error("reset too long");
    property p_wdr_force;
        wr && wb_adr_i == 8'h00 && wb_dat_i[5] && on_reg
            |-> ##[1:2] watchdog_reset;
    endproperty
    a_wdr_force: assert property (p_wdr_force) else $error("no forced reset");
    property p_wdr_gate;
        watchdog_reset |-> $past(on_reg) || $past(on_reg, 2);
    endproperty
    a_wdr_gate: assert property (p_wdr_gate) else $error("reset while off");
endmodule
bind cpw_top cpw_top_asserts u_chk (.clk, .reset_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .watchdog_reset);

/* bench/cpw_load_model.sv */
// load model: integrates the on-time of each channel output
`timescale 1ns/1ps
module cpw_load_model (
    input  wire logic             clk,
    input  wire logic             clr,
    input  wire logic [5:0]       pin,
    output logic      [5:0][15:0] high_cnt
);
    // a resistive load only sees average on-time, not phase
    always_ff @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            high_cnt[i] <= clr ? 16'h0000 : high_cnt[i] + 16'(pin[i]);
        end
    end
endmodule

/* bench/tb_cpw_top.sv */
// testbench: register, pwm duty and watchdog scenarios for cpw_top
`timescale 1ns/1ps
module tb_cpw_top;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             cyc = 1'b0;
    logic             we = 1'b0;
    logic             clr = 1'b0;
    logic [3:0]       sel = 4'hF;
    logic [7:0]       adr = 8'h00;
    logic [31:0]      wdat = 32'h0000_0000;
    logic [31:0]      rdat;
    logic             ack;
    logic             wdr;
    logic             wdr_ack = 1'b0;
    logic [5:0]       pin;
    logic [5:0][15:0] hc;
    int               n_fail = 0;
    int               tests_run = 0;

    // 25 MHz system clock
    always #20 clk = ~clk;

    cpw_top dut (
        .clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .cpu_idle(1'b0), .timer_overflow(1'b0),
        .ext_count_pin(1'b0), .channel_output_pin(pin),
        .watchdog_reset(wdr)
    );
    cpw_load_model load (.clk, .clr, .pin, .high_cnt(hc));

    task automatic report_and_stop();
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask

    // one classic cycle; a missing ack counts as a mismatch
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        int i;
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h00_0000, d};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdat[7:0];
        wdr_ack = wdr;
        cyc <= 1'b0;
        if (ack !== 1'b1) begin
            n_fail++;
            report_and_stop();
        end else begin
            @(posedge clk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk({24'h00_0000, q}, {24'h00_0000, e});
    endtask

    // zero the load, then let exactly n samples accumulate
    task automatic meas(input int n);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n + 1) @(posedge clk);
    endtask

    // watchdog live from reset, frozen source, forced pulse, disable
    task automatic t_wdog();
        int c;
        c = 0;
        while (wdr !== 1'b1 && c < 4000) begin
            @(posedge clk);
            c++;
        end
        chk(32'(c > 3040 && c < 3110), 32'h0000_0001);
        rd(8'h04, 8'h40);
        rd(8'h00, 8'h00);
        rd(8'hFC, 8'h00);
        wr(8'h04, 8'h48);
        rd(8'h04, 8'h40);
        wr(8'h00, 8'h20);
        chk({31'h0000_0000, wdr_ack}, 32'h0000_0001);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h20);
        chk({31'h0000_0000, wdr_ack}, 32'h0000_0000);
        wr(8'h04, 8'h08);
        rd(8'h04, 8'h08);
        wr(8'h00, 8'h40);
    endtask

    // 8-bit: low byte reloads from high after the first wrap
    task automatic t_pwm8();
        wr(8'h20, 8'h4A);
        wr(8'h24, 8'h40);
        wr(8'h28, 8'hC0);
        meas(300);
        meas(1024);
        chk({16'h0000, hc[0]}, 32'h0000_0100);
        rd(8'h00, 8'h41);
        rd(8'h08, 8'h20);
        wr(8'h24, 8'h40);
        meas(512);
        chk({16'h0000, hc[0]}, 32'h0000_0000);
    endtask

    // n-bit on channel 1 through the reload path, length codes 1 to 3
    task automatic t_pwm_enable();
        wr(8'h08, 8'h81);
        wr(8'h34, 8'h80);
        wr(8'h38, 8'h01);
        wr(8'h30, 8'h42);
        wr(8'h28, 8'h00);
        rd(8'h34, 8'h80);
        for (int n = 1; n < 4; n++) begin
            wr(8'h08, {6'h20, n[1:0]});
            meas(2100);
            meas(2048);
            chk({16'h0000, hc[1]}, 32'(2048 - 384 * (8 >> n)));
            chk({16'h0000, hc[0]}, 32'h0000_0800);
        end
    endtask

    // 16-bit on channel 2, counter preset near the top
    task automatic t_pwm16();
        wr(8'h08, 8'h03);
        wr(8'h44, 8'h00);
        wr(8'h48, 8'hFF);
        wr(8'h40, 8'hC2);
        wr(8'h0C, 8'h00);
        wr(8'h10, 8'hFE);
        meas(600);
        chk({16'h0000, hc[2]}, 32'h0000_0100);
        rd(8'h00, 8'hC1);
    endtask

    // lock keeps the watchdog armed after the enable is cleared
    task automatic t_lock();
        wr(8'h04, 8'h28);
        wr(8'h04, 8'h08);
        rd(8'h04, 8'h28);
        wr(8'h00, 8'h20);
        chk({31'h0000_0000, wdr_ack}, 32'h0000_0001);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_wdog();
        t_pwm8();
        t_pwm_enable();
        t_pwm16();
        t_lock();
        report_and_stop();
    end
endmodule
